// file: shared/phy_err_pkg.sv
// Constants, types and register map of the PHY error counter bank
package phy_err_pkg;

  // ----------------------------------------------------------------
  // Management frame
  // ----------------------------------------------------------------
  localparam logic [4:0] PHY_ADDR      = 5'h01;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [5:0] PREAMBLE_LEN  = 6'h20;
  localparam logic [5:0] HDR_BITS      = 6'h0D;
  localparam logic [5:0] TA_BITS       = 6'h02;
  localparam logic [5:0] DATA_BITS     = 6'h10;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_PHY_ADDR      = 5'h12;
  localparam logic [4:0] REG_RX_ERR_FRAME  = 5'h15;
  localparam logic [4:0] REG_RX_SYM_ERR    = 5'h16;
  localparam logic [4:0] REG_RX_PREM_EOF   = 5'h17;
  localparam logic [4:0] REG_RX_10M_EOF    = 5'h18;
  localparam logic [4:0] REG_TX_JABBER     = 5'h19;
  localparam logic [4:0] REG_EQUALIZER     = 5'h1A;
  localparam logic [4:0] REG_LED_SEL       = 5'h1B;

  // ----------------------------------------------------------------
  // Counters, reset values, LED codes
  // ----------------------------------------------------------------
  localparam int         NUM_CNT      = 5;
  localparam int         CNT_W        = 16;
  localparam logic [2:0] SYM_GROUP    = 3'h6;
  localparam logic [15:0] EQ_RST      = 16'h0000;
  localparam logic [2:0] LED_SEL_RST  = 3'h0;
  localparam logic [2:0] LED_ACT_LINK = 3'h0;
  localparam logic [2:0] LED_SPD_COL  = 3'h1;
  localparam logic [2:0] LED_SPD_LINK = 3'h2;
  localparam logic [2:0] LED_ACT_COL  = 3'h3;
  localparam logic [2:0] LED_OFF_OFF  = 3'h4;
  localparam logic [2:0] LED_OFF_ON   = 3'h5;
  localparam logic [2:0] LED_ON_OFF   = 3'h6;
  localparam logic [2:0] LED_ON_ON    = 3'h7;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic frame_active;
    logic sym_valid;
    logic sym_err;
    logic premature_eof;
    logic eof_err_10m;
    logic jabber;
  } rx_event_s;

  typedef struct packed {
    logic activity;
    logic link;
    logic speed;
    logic collision;
  } led_status_s;

  typedef enum logic [2:0] {MD_IDLE, MD_HDR, MD_TA, MD_RDATA, MD_WDATA} mdio_state_e;

endpackage : phy_err_pkg

// file: tb/mdio_master_model.sv
// Management master model driving the clock and data pins
`timescale 1ns/1ps
module mdio_master_model
(
  input  wire logic sys_clk,
  input  wire logic pin,
  output logic      mdc,
  output logic      drv_oe,
  output logic      drv_out
);
  initial
  begin
    mdc = 1'b0;
    drv_oe = 1'b0;
    drv_out = 1'b0;
  end

  // Full frame; the clock stands still low between frames
  task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rdat);
    logic [63:0] fr;
    logic        rdo;
    rdo = (op == phy_err_pkg::OP_READ);
    fr = {32'hFFFFFFFF, 2'b01, op, phy, ra, 2'b10, wd};
    rdat = 16'h0000;
    for (int b = 63; b >= 0; b--)
    begin
      @(posedge sys_clk);
      #1 mdc = 1'b0;
      drv_oe = !(rdo && b < 18);
      drv_out = fr[b];
      repeat (4) @(posedge sys_clk);
      #1 rdat = (rdo && b < 16) ? {rdat[14:0], pin} : rdat;
      mdc = 1'b1;
      repeat (3) @(posedge sys_clk);
    end
    @(posedge sys_clk);
    #1 mdc = 1'b0;
    drv_oe = 1'b0;
  endtask : xfer
endmodule : mdio_master_model

// file: tb/phy_err_props.sv
// Checker of management pin timing and LED outputs
`timescale 1ns/1ps
module phy_err_props
  import phy_err_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        mdc,
  input wire logic        mdio_in,
  input wire logic        mdio_out,
  input wire logic        mdio_oe,
  input wire rx_event_s   rx_event,
  input wire led_status_s led_status,
  input wire logic        activity_led_out,
  input wire logic        link_led_out
);
  logic        mdc_q;
  logic        rise;
  logic        wr_hit;
  logic        exp_act;
  logic        exp_link;
  logic [63:0] sh;
  logic [4:0]  oe_rises;
  logic [3:0]  since;
  logic [3:0]  settle;
  logic [2:0]  sel_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  assign rise = mdc & ~mdc_q;
  assign wr_hit = rise && (sh[62:15] == {32'hFFFFFFFF, 2'b01, OP_WRITE, PHY_ADDR,
                                         REG_LED_SEL, 2'b10});
  assign exp_act = (sel_q[0] ^ sel_q[1]) ? led_status.speed : led_status.activity;
  assign exp_link = sel_q[0] ? led_status.collision : led_status.link;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mdc_q <= 1'b0;
      sh <= '0;
      oe_rises <= 5'h00;
      since <= 4'h0;
      settle <= 4'h0;
      sel_q <= 3'h0;
    end
    else
    begin
      mdc_q <= mdc;
      sh <= rise ? {sh[62:0], mdio_in} : sh;
      oe_rises <= mdio_oe ? oe_rises + 5'(rise) : 5'h00;
      since <= rise ? 4'h0 : ((since == 4'hF) ? since : since + 4'h1);
      settle <= wr_hit ? 4'h0 : ((settle == 4'hF) ? settle : settle + 4'h1);
      sel_q <= wr_hit ? {sh[1:0], mdio_in} : sel_q;
    end
  end

  a_oe_addr: assert property ($rose(mdio_oe) |->
    sh[46:6] == {32'hFFFFFFFF, 2'b01, OP_READ, PHY_ADDR}) else $error("read answer bad frame");
  a_ta_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
    else $error("turnaround bit not low");
  a_oe_bound: assert property (mdio_oe |-> oe_rises <= 5'h11)
    else $error("pin driven too long");
  a_oe_len: assert property ($fell(mdio_oe) |-> oe_rises == 5'h11)
    else $error("pin released early");
  a_oe_due: assert property (oe_rises == 5'h11 |-> ##[0:6] !mdio_oe)
    else $error("pin not released");
  a_data_after_rise: assert property (($rose(mdio_oe) || $fell(mdio_oe) ||
    (mdio_oe && $changed(mdio_out))) |-> since <= 4'h5) else $error("data not on clock rise");
  a_led_forced: assert property (settle >= 4'h9 && sel_q[2] |->
    activity_led_out == sel_q[1] && link_led_out == sel_q[0]) else $error("forced led wrong");
  a_led_source: assert property (settle >= 4'h9 && !sel_q[2] |->
    activity_led_out == $past(exp_act) && link_led_out == $past(exp_link))
    else $error("led source wrong");

  c_read: cover property ($rose(mdio_oe));
  c_write: cover property (wr_hit);
  c_forced: cover property (settle == 4'h9 && sel_q[2]);
  c_bad_sym: cover property (rx_event.frame_active && rx_event.sym_valid && rx_event.sym_err);
endmodule : phy_err_props

bind phy_error_counters_led_select phy_err_props u_props (.sys_clk(sys_clk), .rst_b(rst_b),
  .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .rx_event(rx_event),
  .led_status(led_status), .activity_led_out(activity_led_out), .link_led_out(link_led_out));

// file: tb/tb.sv
// Testbench of the PHY error counter bank and LED select
`timescale 1ns/1ps
module tb;
  import phy_err_pkg::*;
  logic        sys_clk;
  logic        rst_b;
  logic        mdc;
  logic        m_oe;
  logic        m_out;
  logic        mdio_out;
  logic        mdio_oe;
  logic        pin;
  logic        act_led;
  logic        link_led;
  logic        bad;
  logic        ferr;
  logic [31:0] rng;
  logic [15:0] rd;
  logic [15:0] r1;
  rx_event_s   ev;
  led_status_s st;
  int          fail_count;
  int          cmp_count;
  int          cnt [5];
  int          run;
  int          k;
  int          e;

  // Pin level: PHY, else master, else pull-up
  assign pin = mdio_oe ? mdio_out : (m_oe ? m_out : 1'b1);

  phy_error_counters_led_select dut (.sys_clk(sys_clk), .rst_b(rst_b), .mdc(mdc),
    .mdio_in(pin), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .rx_event(ev), .led_status(st),
    .activity_led_out(act_led), .link_led_out(link_led));
  mdio_master_model mst (.sys_clk(sys_clk), .pin(pin), .mdc(mdc), .drv_oe(m_oe),
    .drv_out(m_out));

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  function automatic logic [1:0] exp_led(input logic [2:0] c, input led_status_s s);
    if (c[2])
      return c[1:0];
    return {(c[0] ^ c[1]) ? s.speed : s.activity, c[0] ? s.collision : s.link};
  endfunction : exp_led

  function automatic logic [15:0] sat(input int n);
    return (n > 65535) ? 16'hFFFF : n[15:0];
  endfunction : sat

  task automatic stop_test;
    $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic check(input logic [15:0] got, input logic [15:0] x);
    cmp_count++;
    if (got !== x)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, x);
    end
  endtask : check

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] x);
    mst.xfer(OP_READ, PHY_ADDR, a, 16'h0000, rd);
    check(rd, x);
  endtask : rd_chk

  task automatic rd_cnt(input int i);
    rd_chk(REG_RX_ERR_FRAME + 5'(i), sat(cnt[i]));
    cnt[i] = 0;
  endtask : rd_cnt

  // Drives one cycle of events and keeps the expected counts
  task automatic drive(input rx_event_s v);
    @(posedge sys_clk);
    #1 ev = v;
    if (!v.frame_active)
      run = 0;
    else if (v.sym_valid && !v.sym_err)
      run = 0;
    else if (v.sym_valid)
    begin
      cnt[1] += (run % 6 == 0);
      run++;
    end
    if (!v.frame_active)
      ferr = 1'b0;
    else if (!ferr && ((v.sym_valid && v.sym_err) || v.premature_eof))
    begin
      cnt[0]++;
      ferr = 1'b1;
    end
    cnt[2] += v.premature_eof;
    cnt[3] += v.eof_err_10m;
    cnt[4] += v.jabber;
  endtask : drive

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    fail_count++;
    stop_test;
  end

  initial
  begin
    rst_b = 1'b0;
    ev = '0;
    st = '0;
    rng = 32'h618D78C7;
    fail_count = 0;
    cmp_count = 0;
    cnt = '{default: 0};
    run = 0;
    ferr = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    for (k = 18; k <= 27; k++)
      rd_chk(5'(k), (k == 18) ? 16'h0001 : 16'h0000);
    mst.xfer(OP_WRITE, PHY_ADDR, REG_TX_JABBER, 16'hFFFF, rd);
    rd_chk(REG_TX_JABBER, 16'h0000);
    rng = xs(rng);
    mst.xfer(OP_WRITE, PHY_ADDR, REG_EQUALIZER, rng[15:0], rd);
    rd_chk(REG_EQUALIZER, rng[15:0]);
    for (k = 0; k < 300; k++)
    begin
      rng = xs(rng);
      drive({3'h0, rng[2:0]});
    end
    for (k = 0; k < 8; k++)
      for (e = 0; e < 40; e++)
      begin
        rng = xs(rng);
        // Frame 7 is one unbroken run of bad symbols
        bad = (k == 7) || ((k % 4 != 0) && (rng[1] | rng[2]));
        drive({e < 39, (rng[0] || k == 7) && e < 39, (rng[0] || k == 7) && bad && e < 39,
               k % 4 == 2 && e == 38, 2'h0});
      end
    mst.xfer(OP_READ, 5'h1F, REG_RX_PREM_EOF, 16'h0000, rd);
    check(rd, 16'hFFFF);
    for (k = 0; k < 5; k++)
      rd_cnt(k);
    for (k = 2; k < 5; k++)
      rd_cnt(k);
    for (k = 0; k < 65540; k++)
      drive(6'h03);
    drive(6'h00);
    rd_cnt(4);
    rd_cnt(3);
    fork
      for (e = 0; e < 600; e++)
        drive(6'h01);
      mst.xfer(OP_READ, PHY_ADDR, REG_TX_JABBER, 16'h0000, r1);
    join
    drive(6'h00);
    mst.xfer(OP_READ, PHY_ADDR, REG_TX_JABBER, 16'h0000, rd);
    check(r1 + rd, 16'(cnt[4]));
    for (k = 0; k < 8; k++)
    begin
      mst.xfer(OP_WRITE, PHY_ADDR, REG_LED_SEL, {13'h0, 3'(k)}, rd);
      rng = xs(rng);
      @(posedge sys_clk);
      #1 st = rng[3:0];
      repeat (3) @(posedge sys_clk);
      #1 check({14'h0, act_led, link_led}, {14'h0, exp_led(3'(k), st)});
      rd_chk(REG_LED_SEL, {13'h0, 3'(k)});
    end
    // Reset in mid-run brings back the reset values
    repeat (3) drive(6'h01);
    drive(6'h00);
    @(posedge sys_clk);
    #1 rst_b = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    cnt = '{default: 0};
    rd_cnt(4);
    rd_chk(REG_EQUALIZER, EQ_RST);
    check({14'h0, act_led, link_led}, {14'h0, exp_led(LED_SEL_RST, st)});
    rd_chk(REG_LED_SEL, {13'h0, LED_SEL_RST});
    stop_test;
  end
endmodule : tb

// file: verilog/phy_error_counters_led_select.sv
// PHY error counter bank with LED select, reached over the management data pins
//
// What this block does
// - Errored-frame counter bumps once per bad frame
// - Counters saturate at all ones, clear on read
// - Symbol error counter, saturating, clear on read
// - Six consecutive bad symbols count once
// - Premature end-of-frame counter, saturating, clear on read
// - 10M end-of-frame error counter, saturating, clear-on-read
// - Jabber detection counter, saturating, clear on read
// - Answer only at PHY address 00001b
`timescale 1ns/1ps
module phy_error_counters_led_select
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  input  wire logic                      mdc,
  input  wire logic                      mdio_in,
  output logic                           mdio_out,
  output logic                           mdio_oe,
  input  wire phy_err_pkg::rx_event_s    rx_event,
  input  wire phy_err_pkg::led_status_s  led_status,
  output logic                           activity_led_out,
  output logic                           link_led_out
);
  import phy_err_pkg::*;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic [NUM_CNT-1:0] cnt_sel(input logic [4:0] regad);
    logic [NUM_CNT-1:0] sel;
    sel = '0;
    for (int i = 0; i < NUM_CNT; i++)
    begin
      if (regad == REG_RX_ERR_FRAME + 5'(i))
      begin
        sel[i] = 1'b1;
      end
    end
    return sel;
  endfunction : cnt_sel

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic mdc_s1_reg;
  logic mdc_s2_reg;
  logic mdc_s3_reg;
  logic mdio_s1_reg;
  logic mdio_s2_reg;
  logic mdc_rise;

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mdc_s1_reg  <= 1'b0;
      mdc_s2_reg  <= 1'b0;
      mdc_s3_reg  <= 1'b0;
      mdio_s1_reg <= 1'b1;
      mdio_s2_reg <= 1'b1;
    end
    else
    begin
      mdc_s1_reg  <= mdc;
      mdc_s2_reg  <= mdc_s1_reg;
      mdc_s3_reg  <= mdc_s2_reg;
      mdio_s1_reg <= mdio_in;
      mdio_s2_reg <= mdio_s1_reg;
    end
  end

  assign mdc_rise = mdc_s2_reg & ~mdc_s3_reg;

  // ----------------------------------------------------------------
  // Event qualification
  // ----------------------------------------------------------------
  logic               frame_err_seen_reg;
  logic               frame_err_seen_next;
  logic [2:0]         sym_run_reg;
  logic [2:0]         sym_run_next;
  logic               frame_err_now;
  logic [NUM_CNT-1:0] cnt_inc;

  always_comb
  begin
    frame_err_now       = rx_event.frame_active &
                          (rx_event.sym_err | rx_event.premature_eof);
    frame_err_seen_next = rx_event.frame_active & (frame_err_seen_reg | frame_err_now);
    sym_run_next        = sym_run_reg;
    cnt_inc[0]          = frame_err_now & ~frame_err_seen_reg;
    cnt_inc[1]          = 1'b0;
    if (rx_event.sym_valid)
    begin
      if (rx_event.sym_err)
      begin
        cnt_inc[1]   = (sym_run_reg == 3'h0);
        sym_run_next = (sym_run_reg == SYM_GROUP - 3'h1) ? 3'h0 : sym_run_reg + 3'h1;
      end
      else
      begin
        sym_run_next = 3'h0;
      end
    end
    if (!rx_event.frame_active)
    begin
      sym_run_next = 3'h0;
    end
    cnt_inc[2] = rx_event.premature_eof;
    cnt_inc[3] = rx_event.eof_err_10m;
    cnt_inc[4] = rx_event.jabber;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frame_err_seen_reg <= 1'b0;
      sym_run_reg        <= 3'h0;
    end
    else
    begin
      frame_err_seen_reg <= frame_err_seen_next;
      sym_run_reg        <= sym_run_next;
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  logic [NUM_CNT-1:0] cnt_clr;
  logic [CNT_W-1:0]   cnt_val [NUM_CNT];

  generate
    for (genvar g = 0; g < NUM_CNT; g++)
    begin : g_cnt
      sat_cor_counter u_cnt
      (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .inc     (cnt_inc[g]),
        .clr     (cnt_clr[g]),
        .count   (cnt_val[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Management frame engine and registers
  // ----------------------------------------------------------------
  mdio_state_e   state_reg;
  mdio_state_e   state_next;
  logic [5:0]    cnt_reg;
  logic [5:0]    cnt_next;
  logic [15:0]   shift_reg;
  logic [15:0]   shift_next;
  logic [4:0]    regad_reg;
  logic [4:0]    regad_next;
  logic          is_write_reg;
  logic          is_write_next;
  logic          oe_reg;
  logic          oe_next;
  logic          out_reg;
  logic          out_next;
  logic [15:0]   eq_reg;
  logic [15:0]   eq_next;
  logic [2:0]    led_sel_reg;
  logic [2:0]    led_sel_next;
  logic [15:0]   hdr;
  logic [15:0]   rd_value;
  logic [NUM_CNT-1:0] rd_sel;

  always_comb
  begin
    hdr      = {shift_reg[14:0], mdio_s2_reg};
    rd_sel   = cnt_sel(hdr[4:0]);
    rd_value = 16'h0000;
    for (int i = 0; i < NUM_CNT; i++)
    begin
      if (rd_sel[i])
      begin
        rd_value = cnt_val[i];
      end
    end
    case (hdr[4:0])
      REG_PHY_ADDR:  rd_value = {11'h000, PHY_ADDR};
      REG_EQUALIZER: rd_value = eq_reg;
      REG_LED_SEL:   rd_value = {13'h0000, led_sel_reg};
      default:       rd_value = rd_value;
    endcase
  end

  always_comb
  begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    shift_next    = shift_reg;
    regad_next    = regad_reg;
    is_write_next = is_write_reg;
    oe_next       = oe_reg;
    out_next      = out_reg;
    eq_next       = eq_reg;
    led_sel_next  = led_sel_reg;
    cnt_clr       = '0;
    if (mdc_rise)
    begin
      case (state_reg)
        MD_IDLE:
        begin
          if (mdio_s2_reg)
          begin
            cnt_next = (cnt_reg == PREAMBLE_LEN) ? cnt_reg : cnt_reg + 6'h01;
          end
          else if (cnt_reg == PREAMBLE_LEN)
          begin
            state_next = MD_HDR;
            cnt_next   = 6'h00;
          end
          else
          begin
            cnt_next = 6'h00;
          end
        end
        MD_HDR:
        begin
          shift_next = hdr;
          cnt_next   = cnt_reg + 6'h01;
          if (cnt_reg == HDR_BITS - 6'h01)
          begin
            cnt_next      = 6'h00;
            regad_next    = hdr[4:0];
            is_write_next = (hdr[11:10] == OP_WRITE);
            state_next    = MD_IDLE;
            if (hdr[12] && (hdr[9:5] == PHY_ADDR) &&
                ((hdr[11:10] == OP_READ) || (hdr[11:10] == OP_WRITE)))
            begin
              state_next = MD_TA;
              if (hdr[11:10] == OP_READ)
              begin
                shift_next = rd_value;
                cnt_clr    = cnt_sel(hdr[4:0]);
              end
            end
          end
        end
        MD_TA:
        begin
          cnt_next = cnt_reg + 6'h01;
          if (!is_write_reg)
          begin
            oe_next    = 1'b1;
            out_next   = 1'b0;
            cnt_next   = 6'h00;
            state_next = MD_RDATA;
          end
          else if (cnt_reg == TA_BITS - 6'h01)
          begin
            cnt_next   = 6'h00;
            state_next = MD_WDATA;
          end
        end
        MD_RDATA:
        begin
          cnt_next   = cnt_reg + 6'h01;
          out_next   = shift_reg[15];
          shift_next = {shift_reg[14:0], 1'b0};
          if (cnt_reg == DATA_BITS)
          begin
            oe_next    = 1'b0;
            out_next   = 1'b0;
            cnt_next   = 6'h00;
            state_next = MD_IDLE;
          end
        end
        MD_WDATA:
        begin
          cnt_next   = cnt_reg + 6'h01;
          shift_next = hdr;
          if (cnt_reg == DATA_BITS - 6'h01)
          begin
            cnt_next   = 6'h00;
            state_next = MD_IDLE;
            if (regad_reg == REG_EQUALIZER)
            begin
              eq_next = hdr;
            end
            if (regad_reg == REG_LED_SEL)
            begin
              led_sel_next = hdr[2:0];
            end
          end
        end
        default:
        begin
          state_next = MD_IDLE;
          cnt_next   = 6'h00;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg    <= MD_IDLE;
      cnt_reg      <= 6'h00;
      shift_reg    <= 16'h0000;
      regad_reg    <= 5'h00;
      is_write_reg <= 1'b0;
      oe_reg       <= 1'b0;
      out_reg      <= 1'b0;
      eq_reg       <= EQ_RST;
      led_sel_reg  <= LED_SEL_RST;
    end
    else
    begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      shift_reg    <= shift_next;
      regad_reg    <= regad_next;
      is_write_reg <= is_write_next;
      oe_reg       <= oe_next;
      out_reg      <= out_next;
      eq_reg       <= eq_next;
      led_sel_reg  <= led_sel_next;
    end
  end

  assign mdio_out = out_reg;
  assign mdio_oe  = oe_reg;

  // ----------------------------------------------------------------
  // LED steering
  // ----------------------------------------------------------------
  logic act_led_next;
  logic link_led_next;
  logic act_led_reg;
  logic link_led_reg;

  always_comb
  begin
    case (led_sel_reg)
      LED_ACT_LINK: {act_led_next, link_led_next} = {led_status.activity, led_status.link};
      LED_SPD_COL:  {act_led_next, link_led_next} = {led_status.speed, led_status.collision};
      LED_SPD_LINK: {act_led_next, link_led_next} = {led_status.speed, led_status.link};
      LED_ACT_COL:  {act_led_next, link_led_next} = {led_status.activity, led_status.collision};
      LED_OFF_OFF:  {act_led_next, link_led_next} = 2'h0;
      LED_OFF_ON:   {act_led_next, link_led_next} = 2'h1;
      LED_ON_OFF:   {act_led_next, link_led_next} = 2'h2;
      LED_ON_ON:    {act_led_next, link_led_next} = 2'h3;
      default:      {act_led_next, link_led_next} = 2'h0;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      act_led_reg  <= 1'b0;
      link_led_reg <= 1'b0;
    end
    else
    begin
      act_led_reg  <= act_led_next;
      link_led_reg <= link_led_next;
    end
  end

  assign activity_led_out = act_led_reg;
  assign link_led_out     = link_led_reg;

endmodule : phy_error_counters_led_select

// file: verilog/sat_cor_counter.sv
// Saturating clear-on-read event counter
`timescale 1ns/1ps
module sat_cor_counter
(
  input  wire logic                          sys_clk,
  input  wire logic                          rst_b,
  input  wire logic                          inc,
  input  wire logic                          clr,
  output logic [phy_err_pkg::CNT_W-1:0]      count
);
  import phy_err_pkg::*;

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] base;

  // Clear drops the old value; an event in the same cycle still counts
  always_comb
  begin
    base       = clr ? '0 : count_reg;
    count_next = base;
    if (inc && (base != {CNT_W{1'b1}}))
    begin
      count_next = base + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      count_reg <= '0;
    end
    else
    begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule : sat_cor_counter
